// ---- logic/rtc_calendar_core.sv ----
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module rtc_calendar_core import rtc_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic slow_crystal_in,
    output logic slow_crystal_drive,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);

    // ==========================================================
    // Second tick
    logic secTick;

    rtc_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .reset(reset),
        .slow_crystal_in(slow_crystal_in),
        .slow_crystal_drive(slow_crystal_drive),
        .secTick(secTick)
    );

    // ==========================================================
    // State
    logic [SEC_W-1:0] sec_r, secNxt;
    logic [MIN_W-1:0] min_r, minNxt;
    logic [HOUR_W-1:0] hour_r, hourNxt;
    logic [DAY_W-1:0] day_r, dayNxt;
    logic [31:0] alDaily_r, alDailyNxt;
    logic [31:0] alDate_r, alDateNxt;
    logic [31:0] swCnt_r, swCntNxt;
    logic swRun_r, swRunNxt;
    logic [NUM_EV-1:0] ien_r, ienNxt;
    logic [NUM_EV-1:0] stat_r, statNxt;
    logic chk_r, chkNxt;
    logic ack_r, ackNxt;
    logic [31:0] rdata_r, rdataNxt;
    logic irq_r, irqNxt;

    // ==========================================================
    // Combinational helpers
    logic req, wrEn;
    logic [31:0] bmask, timeWord, timeNew;
    logic secWrap, minWrap, hourWrap, dayWrap;
    logic [NUM_EV-1:0] ev, clr;

    // Byte lanes expanded to a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_mask
        assign bmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end

    always_comb begin
        req = avs_read | avs_write;
        // One wait state: request taken at first edge, answered at second
        ackNxt = req & ~ack_r;
        wrEn = avs_write & ack_r;
        timeWord = {day_r, hour_r, min_r, sec_r};
        timeNew = (timeWord & ~bmask) | (avs_writedata & bmask);

        secWrap = secTick && (sec_r == SEC_MAX);
        minWrap = secWrap && (min_r == MIN_MAX);
        hourWrap = minWrap && (hour_r == HOUR_MAX);
        dayWrap = hourWrap && (day_r == DAY_MAX);

        secNxt = sec_r;
        minNxt = min_r;
        hourNxt = hour_r;
        dayNxt = day_r;
        // Free running on the crystal tick, nothing else stops it
        if (secTick) begin
            secNxt = secWrap ? '0 : sec_r + 1'b1;
        end
        if (secWrap) begin
            minNxt = minWrap ? '0 : min_r + 1'b1;
        end
        if (minWrap) begin
            hourNxt = hourWrap ? '0 : hour_r + 1'b1;
        end
        if (hourWrap) begin
            dayNxt = day_r + 1'b1;
        end

        alDailyNxt = alDaily_r;
        alDateNxt = alDate_r;
        ienNxt = ien_r;
        swCntNxt = swCnt_r;
        swRunNxt = swRun_r;
        ev = '0;
        clr = '0;

        if (swRun_r && secTick) begin
            if (swCnt_r == '0) begin
                swRunNxt = 1'b0;
                ev[EV_STOPWATCH] = 1'b1;
            end else begin
                swCntNxt = swCnt_r - 1'b1;
            end
        end

        // Software write beats a same-cycle tick, except a status clear, which loses to the set
        if (wrEn) begin
            if (avs_address == OFS_TIME) begin
                secNxt = timeNew[SEC_LSB +: SEC_W];
                minNxt = timeNew[MIN_LSB +: MIN_W];
                hourNxt = timeNew[HOUR_LSB +: HOUR_W];
                dayNxt = timeNew[DAY_LSB +: DAY_W];
            end else if (avs_address == OFS_ALARM_DAILY) begin
                alDailyNxt = (alDaily_r & ~bmask) | (avs_writedata & bmask);
            end else if (avs_address == OFS_ALARM_DATE) begin
                alDateNxt = (alDate_r & ~bmask) | (avs_writedata & bmask);
            end else if (avs_address == OFS_STOPWATCH) begin
                swCntNxt = (swCnt_r & ~bmask) | (avs_writedata & bmask);
                swRunNxt = 1'b1;
            end else if (avs_address == OFS_IRQ_ENABLE) begin
                if (avs_byteenable[0]) begin
                    ienNxt = avs_writedata[NUM_EV-1:0];
                end
            end else if (avs_address == OFS_STATUS) begin
                if (avs_byteenable[0]) begin
                    clr = avs_writedata[NUM_EV-1:0];
                end
            end
        end

        // Alarms compare the time one cycle after each tick
        chkNxt = secTick;
        ev[EV_SEC] = secTick;
        ev[EV_MIN] = secWrap;
        ev[EV_HOUR] = minWrap;
        ev[EV_DAY] = hourWrap;
        ev[EV_ALARM_DAILY] = chk_r && (timeWord[DAY_LSB-1:0] == alDaily_r[DAY_LSB-1:0]);
        ev[EV_ALARM_DATE] = chk_r && (timeWord == alDate_r);

        // Set wins over a clear in the same cycle
        statNxt = (stat_r & ~clr) | ev;
        irqNxt = |(statNxt & ienNxt);

        rdataNxt = rdata_r;
        if (avs_read && !ack_r) begin
            if (avs_address == OFS_TIME) begin
                rdataNxt = timeWord;
            end else if (avs_address == OFS_ALARM_DAILY) begin
                rdataNxt = alDaily_r;
            end else if (avs_address == OFS_ALARM_DATE) begin
                rdataNxt = alDate_r;
            end else if (avs_address == OFS_STOPWATCH) begin
                rdataNxt = swCnt_r;
            end else if (avs_address == OFS_IRQ_ENABLE) begin
                rdataNxt = {25'h000_0000, ien_r};
            end else if (avs_address == OFS_STATUS) begin
                rdataNxt = {23'h00_0000, swRun_r, 1'b0, stat_r};
            end else begin
                rdataNxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sec_r <= RST_TIME[SEC_LSB +: SEC_W];
            min_r <= RST_TIME[MIN_LSB +: MIN_W];
            hour_r <= RST_TIME[HOUR_LSB +: HOUR_W];
            day_r <= RST_TIME[DAY_LSB +: DAY_W];
            alDaily_r <= RST_ALARM;
            alDate_r <= RST_ALARM;
            swCnt_r <= RST_STOPWATCH;
            swRun_r <= 1'b0;
            ien_r <= RST_IEN;
            stat_r <= RST_STAT;
            chk_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end else begin
            sec_r <= secNxt;
            min_r <= minNxt;
            hour_r <= hourNxt;
            day_r <= dayNxt;
            alDaily_r <= alDailyNxt;
            alDate_r <= alDateNxt;
            swCnt_r <= swCntNxt;
            swRun_r <= swRunNxt;
            ien_r <= ienNxt;
            stat_r <= statNxt;
            chk_r <= chkNxt;
            ack_r <= ackNxt;
            rdata_r <= rdataNxt;
            irq_r <= irqNxt;
        end
    end

    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;
    assign irq = irq_r;

    // ==========================================================
    // Checks
    a_sec_range: assert property (@(posedge clk_sys) disable iff (reset)
        sec_r <= SEC_MAX && min_r <= MIN_MAX && hour_r <= HOUR_MAX)
        else $error("Time counter out of range");

    a_min_carry: assert property (@(posedge clk_sys) disable iff (reset)
        (secTick && sec_r == SEC_MAX && min_r != MIN_MAX && !wrEn)
        |=> sec_r == '0 && min_r == $past(min_r) + 1'b1)
        else $error("Minute did not advance on seconds wrap");

    a_sec_step: assert property (@(posedge clk_sys) disable iff (reset)
        (secTick && sec_r != SEC_MAX && !wrEn) |=> sec_r == $past(sec_r) + 1'b1)
        else $error("Seconds did not advance on tick");

    a_day_event: assert property (@(posedge clk_sys) disable iff (reset)
        (secTick && sec_r == SEC_MAX && min_r == MIN_MAX && hour_r == HOUR_MAX)
        |=> stat_r[EV_DAY] && stat_r[EV_HOUR] && stat_r[EV_MIN])
        else $error("Day rollover flags not set");

    a_alarm_date: assert property (@(posedge clk_sys) disable iff (reset)
        (chk_r && timeWord == alDate_r) |=> stat_r[EV_ALARM_DATE])
        else $error("Date alarm missed");

    a_alarm_daily: assert property (@(posedge clk_sys) disable iff (reset)
        (chk_r && timeWord[DAY_LSB-1:0] == alDaily_r[DAY_LSB-1:0] && ien_r[EV_ALARM_DAILY]
        && !wrEn) |=> irq)
        else $error("Daily alarm interrupt missing");

    a_sw_decrement: assert property (@(posedge clk_sys) disable iff (reset)
        (swRun_r && secTick && swCnt_r != '0 && !wrEn) |=> swCnt_r == $past(swCnt_r) - 1'b1)
        else $error("Stopwatch did not decrement");

    a_sw_underflow: assert property (@(posedge clk_sys) disable iff (reset)
        (swRun_r && secTick && swCnt_r == '0 && !wrEn) |=> !swRun_r && stat_r[EV_STOPWATCH])
        else $error("Stopwatch underflow not flagged");

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        (stat_r[EV_SEC] && !(wrEn && avs_address == OFS_STATUS)) |=> stat_r[EV_SEC])
        else $error("Status flag lost without clear");

    a_irq_or: assert property (@(posedge clk_sys) disable iff (reset)
        irq == |(stat_r & ien_r))
        else $error("Interrupt output not OR of enabled flags");

    // ==========================================================
    // Bus and register checks
    // Exactly one wait state, so a master never waits on a stale answer
    a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (reset)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("Waitrequest held for more than one cycle");

    a_status_read: assert property (@(posedge clk_sys) disable iff (reset)
        (avs_read && !ack_r && avs_address == OFS_STATUS)
        |=> avs_readdata[STAT_SW_RUN] == $past(swRun_r) && avs_readdata[31:STAT_SW_RUN+1] == '0
        && avs_readdata[STAT_SW_RUN-1:NUM_EV] == '0)
        else $error("Status read shows wrong run bit or reserved bits");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && avs_address == OFS_STATUS && avs_byteenable[0] && avs_writedata[EV_SEC]
        && !secTick) |=> !stat_r[EV_SEC])
        else $error("Write of one did not clear seconds flag");

    a_time_load: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && avs_address == OFS_TIME && avs_byteenable == 4'hF)
        |=> timeWord == $past(avs_writedata))
        else $error("Time write did not load counters");

    // ==========================================================
    // Counter and event checks
    a_hour_carry: assert property (@(posedge clk_sys) disable iff (reset)
        (minWrap && !hourWrap && !wrEn) |=> hour_r == $past(hour_r) + 1'b1)
        else $error("Hour did not advance on minutes wrap");

    a_day_carry: assert property (@(posedge clk_sys) disable iff (reset)
        (hourWrap && !wrEn) |=> day_r == $past(day_r) + 1'b1)
        else $error("Day did not advance on hours wrap");

    a_sec_event: assert property (@(posedge clk_sys) disable iff (reset)
        secTick |=> stat_r[EV_SEC])
        else $error("Seconds flag not set on tick");

    a_min_event: assert property (@(posedge clk_sys) disable iff (reset)
        secWrap |=> stat_r[EV_MIN])
        else $error("Minutes flag not set on seconds wrap");

    a_daily_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (chk_r && timeWord[DAY_LSB-1:0] == alDaily_r[DAY_LSB-1:0])
        |=> stat_r[EV_ALARM_DAILY])
        else $error("Daily alarm flag missed");

    // Alarms must only fire from the post-tick compare, never from a register write
    a_alarm_after_check: assert property (@(posedge clk_sys) disable iff (reset)
        ($rose(stat_r[EV_ALARM_DATE]) || $rose(stat_r[EV_ALARM_DAILY])) |-> $past(chk_r))
        else $error("Alarm flag raised outside a compare cycle");

    // ==========================================================
    // Stopwatch checks
    a_sw_load: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && avs_address == OFS_STOPWATCH && avs_byteenable == 4'hF)
        |=> swRun_r && swCnt_r == $past(avs_writedata))
        else $error("Stopwatch write did not load and start");

    a_sw_idle: assert property (@(posedge clk_sys) disable iff (reset)
        (!swRun_r && !(wrEn && avs_address == OFS_STOPWATCH))
        |=> swCnt_r == $past(swCnt_r))
        else $error("Stopped stopwatch changed its count");

endmodule

`default_nettype wire

// ---- logic/rtc_pkg.sv ----
package rtc_pkg;

    // ==========================================================
    // Crystal prescaler
    localparam int CRYSTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int PRESCALE_W = 15;
    localparam logic [PRESCALE_W-1:0] PRESCALE_MAX = PRESCALE_W'(CRYSTAL_HZ / TICK_HZ - 1);

    // ==========================================================
    // Counter widths and limits
    localparam int SEC_W = 6;
    localparam int MIN_W = 6;
    localparam int HOUR_W = 5;
    localparam int DAY_W = 15;
    localparam logic [SEC_W-1:0] SEC_MAX = 6'h3B;
    localparam logic [MIN_W-1:0] MIN_MAX = 6'h3B;
    localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
    localparam logic [DAY_W-1:0] DAY_MAX = 15'h7FFF;

    // ==========================================================
    // Time word layout
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 6;
    localparam int HOUR_LSB = 12;
    localparam int DAY_LSB = 17;

    // ==========================================================
    // Register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_TIME = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_ALARM_DAILY = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_ALARM_DATE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STOPWATCH = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

    // ==========================================================
    // Event bit positions in enable and status
    localparam int NUM_EV = 7;
    localparam int EV_SEC = 0;
    localparam int EV_MIN = 1;
    localparam int EV_HOUR = 2;
    localparam int EV_DAY = 3;
    localparam int EV_ALARM_DAILY = 4;
    localparam int EV_ALARM_DATE = 5;
    localparam int EV_STOPWATCH = 6;
    localparam int STAT_SW_RUN = 8;

    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_TIME = 32'h0000_0000;
    localparam logic [31:0] RST_ALARM = 32'h0000_0000;
    localparam logic [31:0] RST_STOPWATCH = 32'h0000_0000;
    localparam logic [NUM_EV-1:0] RST_IEN = 7'h00;
    localparam logic [NUM_EV-1:0] RST_STAT = 7'h00;

endpackage

// ---- logic/rtc_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtc_prescaler import rtc_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic slow_crystal_in,
    output logic slow_crystal_drive,
    output logic secTick
);

    // ==========================================================
    // Synchroniser and divider state
    logic sync1_r, sync2_r, prev_r, drive_r, tick_r;
    logic prevNxt, driveNxt, tickNxt;
    logic [PRESCALE_W-1:0] cnt_r, cntNxt;
    logic rise;

    // Crystal edges are counted in the system domain; needs clk_sys well above 65 kHz
    always_comb begin
        rise = sync2_r & ~prev_r;
        prevNxt = sync2_r;
        driveNxt = ~sync2_r;
        cntNxt = cnt_r + PRESCALE_W'(rise);
        tickNxt = rise && (cnt_r == PRESCALE_MAX);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            drive_r <= 1'b0;
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            sync1_r <= slow_crystal_in;
            sync2_r <= sync1_r;
            prev_r <= prevNxt;
            drive_r <= driveNxt;
            cnt_r <= cntNxt;
            tick_r <= tickNxt;
        end
    end

    assign slow_crystal_drive = drive_r;
    assign secTick = tick_r;

    // ==========================================================
    // Checks
    a_tick_wraps: assert property (@(posedge clk_sys) disable iff (reset)
        secTick |-> cnt_r == '0 && $past(cnt_r) == PRESCALE_MAX)
        else $error("Second tick without full prescaler wrap");

endmodule

`default_nettype wire

// ---- verif/rtc_crystal_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtc_crystal_model #(
    parameter int HALF_NS = 12
) (
    input var int edgeLimit,
    output logic slow_crystal_in,
    output int riseCount
);
    // ==========================================================
    // Oscillator
    // Runs far above 32.768 kHz so one second fits the run; each level lasts
    // over one system period so the synchroniser cannot miss it.
    // Rests low once the edge budget is spent, so a tick lands at a known edge.
    // Ideal edges: the drive return is not looped back into the oscillation.
    initial begin
        slow_crystal_in = 1'b0;
        riseCount = 0;
        forever begin
            #(HALF_NS);
            if (slow_crystal_in) begin
                slow_crystal_in = 1'b0;
            end else if (riseCount < edgeLimit) begin
                slow_crystal_in = 1'b1;
                riseCount = riseCount + 1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- verif/test_rtc_calendar_alarm_stopwatch.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_rtc_calendar_alarm_stopwatch import rtc_pkg::*;;
    logic clk_sys, reset, xtalIn, xtalDrive, avsRead, avsWrite, avsWaitrequest, irq;
    logic [ADDR_W-1:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata, rdData;
    logic [3:0] avsByteenable;
    int edgeLimit, riseCount, badCount, numChecks, cycles;

    rtc_calendar_core dut (.clk_sys(clk_sys), .reset(reset), .slow_crystal_in(xtalIn),
        .slow_crystal_drive(xtalDrive), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .irq(irq));

    rtc_crystal_model xtal (.edgeLimit(edgeLimit),
        .slow_crystal_in(xtalIn), .riseCount(riseCount));

    // ==========================================================
    // Clock and timeout
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // One second of crystal takes about 79k cycles at the model's rate
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            badCount = badCount + 1;
            conclude();
        end
    end

    // ==========================================================
    // Helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks = numChecks + 1;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            badCount = badCount + 1;
        end
    endtask

    // Request stands from just after a rising edge until the rising edge that
    // sees waitrequest low; readdata is taken at that same edge, then released.
    task automatic busOp(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys);
        avsAddress <= a;
        avsWritedata <= d;
        avsByteenable <= be;
        avsWrite <= wr;
        avsRead <= ~wr;
        forever begin
            @(posedge clk_sys);
            if (avsWaitrequest === 1'b0) break;
        end
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        busOp(1'b1, a, d, 4'hF, rdData);
    endtask

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        busOp(1'b0, a, 32'h0000_0000, 4'hF, rdData);
        chk(rdData, exp);
    endtask

    task automatic irqIs(input logic exp);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask

    task automatic crystalTo(input int n);
        edgeLimit = n;
        while (riseCount < n) @(posedge clk_sys);
        repeat (10) @(posedge clk_sys);
    endtask

    function automatic logic [31:0] mk(input logic [DAY_W-1:0] d, input logic [HOUR_W-1:0] h,
            input logic [MIN_W-1:0] m, input logic [SEC_W-1:0] s);
        return {d, h, m, s};
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = '0;
        avsWritedata = '0;
        avsByteenable = 4'hF;
        edgeLimit = 0;
        badCount = 0;
        numChecks = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        // Every register clear after reset, unmapped place included
        for (int a = 0; a <= 24; a += 4) begin
            rc(ADDR_W'(a), 32'h0000_0000);
        end
        wr(5'h18, 32'hFFFF_FFFF);
        rc(5'h18, 32'h0000_0000);
        rc(OFS_TIME, 32'h0000_0000);
        busOp(1'b1, OFS_ALARM_DAILY, 32'hFFFF_FFFF, 4'h1, rdData);
        rc(OFS_ALARM_DAILY, 32'h0000_00FF);
        // Last second of the last day: one tick wraps every counter
        wr(OFS_TIME, mk(DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX));
        rc(OFS_TIME, mk(DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX));
        wr(OFS_ALARM_DAILY, mk(15'h0009, 5'h00, 6'h00, 6'h00));
        wr(OFS_ALARM_DATE, mk(15'h0000, 5'h00, 6'h00, 6'h00));
        wr(OFS_STOPWATCH, 32'h0000_0000);
        wr(OFS_IRQ_ENABLE, 32'h0000_0000);
        rc(OFS_STATUS, 32'h0000_0100);
        // One crystal edge short of a second: nothing may move yet
        crystalTo(32767);
        rc(OFS_TIME, mk(DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX));
        rc(OFS_STATUS, 32'h0000_0100);
        crystalTo(32768);
        rc(OFS_TIME, 32'h0000_0000);
        rc(OFS_STATUS, 32'h0000_007F);
        rc(OFS_STOPWATCH, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // Each source alone: enable drives irq, clearing its flag drops it
        for (int i = 0; i < NUM_EV; i++) begin
            wr(OFS_IRQ_ENABLE, 32'h0000_0001 << i);
            irqIs(1'b1);
            wr(OFS_STATUS, 32'h0000_0001 << i);
            irqIs(1'b0);
        end
        rc(OFS_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, xtalDrive}, 32'h0000_0001);
        conclude();
    end
endmodule

`default_nettype wire
